// ---- test_wwc_window_supervisor.sv ----
`timescale 1ns/1ns
module test_wwc_window_supervisor;
  import wwc_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic sw_req = 1'b1;
  wwc_dev_mode_type dev_mode = WWC_DEV_STANDBY;
  logic sck, cs_n, mosi, miso, sw_out, dis, rst_act, sby, wake;
  logic [7:0] v;
  int failures = 0;
  int n_tests = 0;
  int n_sby = 0;
  int n_wake = 0;
  // System clock and a count of reset-end pulses.
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (sby === 1'b1)
      n_sby++;
  // Count of cyclic wake-up pulses.
  always @(posedge clk_sys)
    if (wake === 1'b1)
      n_wake++;
  // Short tick keeps the run brief.
  wwc_window_supervisor #(.TICK_CYC(20)) dut_u (.clk_sys(clk_sys),
    .rstn(rstn), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(), .dev_mode(dev_mode),
    .regulator_switch_req(sw_req), .regulator_switch_out(sw_out),
    .io_supply_discharge(dis), .mcu_reset_active(rst_act),
    .standby_req(sby), .wake_event(wake));
  wwc_host_model host_u (.clk_sys(clk_sys), .spi_miso(miso),
    .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host_u.xfer({a, 1'b1, 8'h00}, v);
    chk(v, e);
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer({a, 1'b0, d}, v);
  endtask : wr
  // Waits a bounded time for the reset output to reach a level.
  task automatic wait_rst(input logic lvl);
    int k;
    for (k = 0; k < 800 && rst_act !== lvl; k++)
      @(posedge clk_sys);
    chk({7'h0, rst_act}, {7'h0, lvl});
    if (rst_act !== lvl)
      tally_and_finish();
  endtask : wait_rst
  task automatic t_reset();
    rd(ADDR_CFG_ONE, 8'h22);
    rd(ADDR_CFG_TWO, 8'h47);
    rd(ADDR_STATUS, 8'h80);
    chk({7'h0, sw_out}, 8'h01);
  endtask : t_reset
  task automatic t_corrupt();
    wr(ADDR_CFG_ONE, 8'h02);
    rd(ADDR_STATUS, 8'hc0);
    wr(ADDR_CFG_TWO, 8'h07);
    rd(ADDR_CFG_TWO, 8'h47);
    wr(ADDR_STATUS, 8'h40);
  endtask : t_corrupt
  task automatic t_illegal();
    dev_mode <= WWC_DEV_NORMAL;
    wr(ADDR_CFG_TWO, 8'h18);
    rd(ADDR_STATUS, 8'ha0);
    rd(ADDR_CFG_TWO, 8'h47);
    dev_mode <= WWC_DEV_STANDBY;
    wr(ADDR_STATUS, 8'h20);
  endtask : t_illegal
  // Period 16 ms is 640 clocks; a frame takes about 350.
  task automatic t_timeout();
    wr(ADDR_CFG_TWO, 8'h18);
    rd(ADDR_CFG_TWO, 8'h18);
    wr(ADDR_CFG_ONE, 8'h41);
    host_u.service();
    host_u.service();
    wr(ADDR_SERVICE, 8'haa);
    chk({7'h0, rst_act}, 8'h00);
    wait_rst(1'b1);
    chk({6'h0, sw_out, dis}, 8'h01);
    wait_rst(1'b0);
    @(posedge clk_sys);
    chk(n_sby[7:0], 8'h01);
    wr(ADDR_CFG_ONE, 8'h22);
    rd(ADDR_STATUS, 8'h88);
  endtask : t_timeout
  // Window mode, prescale 3.5: period 112 ticks, first half 1120 clocks.
  task automatic t_window();
    wr(ADDR_STATUS, 8'h08);
    wr(ADDR_CFG_ONE, 8'h99);
    dev_mode <= WWC_DEV_NORMAL;
    host_u.service();
    wait_rst(1'b1);
    wait_rst(1'b0);
    rd(ADDR_STATUS, 8'h12);
    repeat (800) @(posedge clk_sys);
    host_u.service();
    chk({7'h0, rst_act}, 8'h00);
    rd(ADDR_STATUS, 8'h12);
    wr(ADDR_CFG_TWO, 8'h18);
    wait_rst(1'b1);
    wait_rst(1'b0);
    dev_mode <= WWC_DEV_STANDBY;
    wr(ADDR_CFG_ONE, 8'h22);
    rd(ADDR_STATUS, 8'ha2);
    wr(ADDR_STATUS, 8'h22);
  endtask : t_window
  // Time-out mode kept running in Sleep gives a cyclic wake-up.
  task automatic t_sleep();
    wr(ADDR_CFG_ONE, 8'h44);
    dev_mode <= WWC_DEV_SLEEP;
    wait_rst(1'b1);
    wait_rst(1'b0);
    chk(n_wake[7:0], 8'h01);
    dev_mode <= WWC_DEV_STANDBY;
    wr(ADDR_CFG_ONE, 8'h22);
    rd(ADDR_STATUS, 8'h84);
  endtask : t_sleep
  // Reset for five cycles, then the scenarios in turn.
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (5) @(posedge clk_sys);
    t_reset();
    t_corrupt();
    t_illegal();
    t_timeout();
    t_window();
    t_sleep();
    tally_and_finish();
  end
endmodule : test_wwc_window_supervisor

// ---- wwc_host_model.sv ----
`timescale 1ns/1ns
module wwc_host_model
  import wwc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic spi_miso,
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_mosi
);
  // Idle bus: clock low, select high.
  initial
  begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // One 16-bit frame, mode 0, MSB first, 20 clocks per serial clock.
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    spi_cs_n <= 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      spi_sck <= 1'b0;
      spi_mosi <= f[i];
      repeat (10) @(posedge clk_sys);
      spi_sck <= 1'b1;
      rd = {rd[6:0], spi_miso};
      repeat (10) @(posedge clk_sys);
    end
    spi_sck <= 1'b0;
    repeat (10) @(posedge clk_sys);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~f[0]; // Released line shows the inverse.
    repeat (10) @(posedge clk_sys);
  endtask : xfer
  // Writes the restart pattern.
  task automatic service();
    logic [7:0] d;
    xfer({ADDR_SERVICE, 1'b0, SERVICE_PATTERN}, d);
  endtask : service
endmodule : wwc_host_model

// ---- wwc_pkg.sv ----
package wwc_pkg;

  // Register offsets on the serial port.
  localparam logic [6:0] ADDR_CFG_ONE = 7'h36;
  localparam logic [6:0] ADDR_CFG_TWO = 7'h37;
  localparam logic [6:0] ADDR_STATUS  = 7'h38;
  localparam logic [6:0] ADDR_SERVICE = 7'h39;

  // Values after reset of the two configuration registers.
  localparam logic [7:0] CFG_ONE_RESET = 8'h22;
  localparam logic [7:0] CFG_TWO_RESET = 8'h47;

  // Field positions in the first configuration register.
  localparam int MODE_MSB      = 7;
  localparam int MODE_LSB      = 5;
  localparam int PRESCALE_MSB  = 4;
  localparam int PRESCALE_LSB  = 3;
  localparam int SLEEP_RUN_POS = 2;
  localparam int LONG_WIN_POS  = 1;
  localparam int DISCHARGE_POS = 0;

  // Field positions in the second configuration register.
  localparam int PERIOD_MSB = 7;
  localparam int PERIOD_LSB = 4;
  localparam int PULSE_MSB  = 3;
  localparam int PULSE_LSB  = 0;

  // Status bit positions.
  localparam int ST_OFF_POS   = 7;
  localparam int ST_CORRUPTED_ACCESS_FLAG_POS  = 6;
  localparam int ST_ILL_POS   = 5;
  localparam int ST_TRIGS_POS = 4;
  localparam int ST_OF_POS    = 3;
  localparam int ST_OFSLP_POS = 2;
  localparam int ST_ETRIG_POS = 1;

  // Supervisor mode codes.
  localparam logic [2:0] MODE_OFF     = 3'h1;
  localparam logic [2:0] MODE_TIMEOUT = 3'h2;
  localparam logic [2:0] MODE_WINDOW  = 3'h4;

  // Service pattern written to the service register.
  localparam logic [7:0] SERVICE_PATTERN = 8'h55;

  // Time base: one tick is half a millisecond.
  localparam int CLK_MHZ     = 125;
  localparam int TICK_US     = 500;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int DIV_W       = 17;
  localparam int CNT_W       = 16;

  // Long open window, least value.
  localparam int LONG_WIN_MS    = 600;
  localparam int LONG_WIN_TICKS = LONG_WIN_MS * 1000 / TICK_US;

  // Serial frame length in bits.
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_BITS  = 5'h08;

  typedef enum logic [1:0] {
    WWC_DEV_STANDBY = 2'h0,
    WWC_DEV_NORMAL  = 2'h1,
    WWC_DEV_SLEEP   = 2'h2,
    WWC_DEV_OTHER   = 2'h3
  } wwc_dev_mode_type;

  typedef enum logic [4:0] {
    WWC_WD_OFF  = 5'h01,
    WWC_WD_LONG = 5'h02,
    WWC_WD_RUN  = 5'h04,
    WWC_WD_HOLD = 5'h08,
    WWC_WD_RST  = 5'h10
  } wwc_wd_state_type;

  // One decoded access from the serial port.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } wwc_spi_req_type;

  // Whole state of the serial slave.
  typedef struct packed {
    logic            sck_s1;
    logic            sck_s2;
    logic            sck_prev;
    logic            cs_s1;
    logic            cs_s2;
    logic            cs_prev;
    logic            mosi_s1;
    logic            mosi_s2;
    logic [4:0]      bits;
    logic [15:0]     shift_in;
    logic [7:0]      tx;
    logic            load;
    logic            miso;
    wwc_spi_req_type req;
  } wwc_spi_state_type;

  // Whole state of the supervisor.
  typedef struct packed {
    wwc_wd_state_type st;
    logic [7:0]       cfg1;
    logic [7:0]       cfg2;
    logic             corrupted_access_flag;
    logic             illconf;
    logic             of_flag;
    logic             ofslp;
    logic             etrig;
    logic [DIV_W-1:0] div;
    logic             tick;
    logic [CNT_W-1:0] cnt;
    logic             prev_sleep;
    logic             sw_out;
    logic             prev_sw;
    logic             discharge;
    logic             standby_req;
    logic             wake;
  } wwc_wd_regs_type;

  // True for a legal redundant 4-bit code of period or pulse length.
  function automatic logic wwc_code4_ok(input logic [3:0] c);
    return (c == 4'h8) || (c == 4'h1) || (c == 4'h2) || (c == 4'hb) ||
           (c == 4'h4) || (c == 4'hd) || (c == 4'he) || (c == 4'h7);
  endfunction : wwc_code4_ok

  // True for a legal supervisor mode code.
  function automatic logic wwc_mode_ok(input logic [2:0] m);
    return (m == MODE_OFF) || (m == MODE_TIMEOUT) || (m == MODE_WINDOW);
  endfunction : wwc_mode_ok

  // Base period in milliseconds for a period code.
  function automatic int wwc_period_ms(input logic [3:0] c);
    case (c)
      4'h8: return 8;
      4'h1: return 16;
      4'h2: return 32;
      4'hb: return 64;
      4'hd: return 256;
      4'he: return 1024;
      4'h7: return 4096;
      default: return 128;
    endcase
  endfunction : wwc_period_ms

  // Period in ticks: base times prescale, factor held in half steps.
  function automatic logic [CNT_W-1:0] wwc_period_ticks(
    input logic [3:0] c,
    input logic [1:0] pre
  );
    int halves;
    case (pre)
      2'h1: halves = 3;
      2'h2: halves = 5;
      2'h3: halves = 7;
      default: halves = 2;
    endcase
    return CNT_W'(wwc_period_ms(c) * halves * 1000 / (2 * TICK_US));
  endfunction : wwc_period_ticks

  // Reset pulse in ticks, least length rounded up.
  function automatic logic [CNT_W-1:0] wwc_pulse_ticks(input logic [3:0] c);
    int us;
    case (c)
      4'h8: us = 1000;
      4'h1: us = 3600;
      4'h2: us = 10000;
      4'hb: us = 20000;
      4'h4: us = 40000;
      4'hd: us = 60000;
      4'he: us = 100000;
      default: us = 150000;
    endcase
    return CNT_W'((us + TICK_US - 1) / TICK_US);
  endfunction : wwc_pulse_ticks

endpackage : wwc_pkg

// ---- wwc_spi_slave.sv ----
`timescale 1ns/1ns
module wwc_spi_slave
  import wwc_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            rstn,
  input  wire logic            spi_sck,
  input  wire logic            spi_cs_n,
  input  wire logic            spi_mosi,
  input  wire logic [7:0]      rd_data,
  output wwc_spi_req_type      req,
  output logic                 spi_miso,
  output logic                 spi_miso_oe
);

  wwc_spi_state_type r_reg;
  wwc_spi_state_type r_next;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_rise;
  logic              cs_fall;

  // Edges are found on the second synchroniser stage only.
  assign sck_rise = r_reg.sck_s2 & ~r_reg.sck_prev;
  assign sck_fall = ~r_reg.sck_s2 & r_reg.sck_prev;
  assign cs_rise  = r_reg.cs_s2 & ~r_reg.cs_prev;
  assign cs_fall  = ~r_reg.cs_s2 & r_reg.cs_prev;

  // Frame decode: address byte with read flag in bit 0, then data byte.
  always_comb
  begin
    r_next          = r_reg;
    r_next.sck_s1   = spi_sck;
    r_next.sck_s2   = r_reg.sck_s1;
    r_next.sck_prev = r_reg.sck_s2;
    r_next.cs_s1    = spi_cs_n;
    r_next.cs_s2    = r_reg.cs_s1;
    r_next.cs_prev  = r_reg.cs_s2;
    r_next.mosi_s1  = spi_mosi;
    r_next.mosi_s2  = r_reg.mosi_s1;
    r_next.req.wr   = 1'b0;
    r_next.req.rd   = 1'b0;
    r_next.load     = 1'b0;
    if (r_reg.load)
    begin
      r_next.tx   = rd_data;
      r_next.miso = rd_data[7];
    end
    if (cs_fall)
    begin
      r_next.bits = 5'h00;
      r_next.miso = 1'b0;
    end
    else if (cs_rise)
    begin
      // Only a whole frame that is not marked as a read writes.
      if (r_reg.bits == FRAME_BITS && !r_reg.shift_in[8])
      begin
        r_next.req.wr   = 1'b1;
        r_next.req.addr = r_reg.shift_in[15:9];
        r_next.req.data = r_reg.shift_in[7:0];
      end
    end
    else if (!r_reg.cs_s2 && sck_rise)
    begin
      r_next.shift_in = {r_reg.shift_in[14:0], r_reg.mosi_s2};
      if (r_reg.bits != 5'h1f)
      begin
        r_next.bits = r_reg.bits + 5'h01;
      end
      if (r_reg.bits == ADDR_BITS - 5'h01)
      begin
        r_next.req.addr = r_reg.shift_in[6:0];
        r_next.req.rd   = 1'b1;
        r_next.load     = 1'b1;
      end
    end
    else if (!r_reg.cs_s2 && sck_fall && r_reg.bits > ADDR_BITS)
    begin
      r_next.tx   = {r_reg.tx[6:0], 1'b0};
      r_next.miso = r_reg.tx[6];
    end
  end

  // State register; the chip select idles high.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      r_reg        <= '0;
      r_reg.cs_s1  <= 1'b1;
      r_reg.cs_s2  <= 1'b1;
      r_reg.cs_prev <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign req         = r_reg.req;
  assign spi_miso    = r_reg.miso;
  assign spi_miso_oe = ~r_reg.cs_s2;

endmodule : wwc_spi_slave

// ---- wwc_window_supervisor.sv ----
// Notes on behaviour
// R1: Supervisor is off after power-up; mode field resets to the off code.
// R2: Window mode behaves as time-out until the device is in Normal mode.
// R3: In window mode only a trigger inside the open window restarts.
// R4: Time-out mode counts continuously; any trigger before expiry restarts.
// R5: Time-out mode can wake the microcontroller periodically.
// R6: Configuration writes only accepted in Standby; host configures first.
// R7: Once enabled the supervisor uses the latest written configuration.
// R8: Every accepted configuration write restarts the timer and applies at once.
// R9: Configuration write outside Standby resets the host and flags it; if the supervisor is off or a code is invalid, only a flag is set.
// R10: After a supervisor reset completes the device goes to Standby.
// R11: A reset holds the regulator switch off for the pulse length.
// R12: Prescale bits 4:3 multiply the period by 1, 1.5, 2.5 or 3.5.
// R13: Sleep-run bit 2, default 0, keeps the supervisor running in Sleep.
// R14: Sleep entry with sleep-run set clears and restarts the counter.
// R15: Sleep entry with sleep-run clear holds until the switch rises.
// R16: Long-window bit 1, default 1, starts a long window on switch rise.
// R17: Discharger bit 0 enables supply discharge during supervisor reset.
// R18: Period field bits 7:4 selects base period 8 to 4096 ms.
// R19: The selected period serves both window and time-out mode.
// R20: Pulse field selects reset pulse length, default 150 to 190 ms.
// R21: Writing 01010101 to the service register restarts the timer.
// R22: Early trigger or overflow in window mode resets; late trigger restarts.
// R23: Invalid code write is abandoned and sets the corrupted-access flag.
// R24: Long window of 600 ms follows activation; no trigger means reset.
// R25: Overflow in time-out mode is recorded in the status register.
// R26: A service write with another value leaves the timer alone.
// R27: Counter runs on the local clock; serial events are synchronised.
`timescale 1ns/1ns
module wwc_window_supervisor
  import wwc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             spi_sck,
  input  wire logic             spi_cs_n,
  input  wire logic             spi_mosi,
  output logic                  spi_miso,
  output logic                  spi_miso_oe,
  input  wwc_dev_mode_type      dev_mode,
  input  wire logic             regulator_switch_req,
  output logic                  regulator_switch_out,
  output logic                  io_supply_discharge,
  output logic                  mcu_reset_active,
  output logic                  standby_req,
  output logic                  wake_event
);

  wwc_wd_regs_type  r_reg;
  wwc_wd_regs_type  r_next;
  wwc_spi_req_type  req;
  logic [7:0]       rd_data;
  logic             cfg_wr;
  logic             cfg_ok;
  logic             trig_wr;
  logic             trig_ok;
  logic             win_act;
  logic             sw_rise;
  logic             sleep_entry;
  logic             in_first_half;
  logic [7:0]       new_cfg1;
  logic [7:0]       new_cfg2;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] pulse;

  // Serial slave; its three serial inputs pass two flip-flops inside.
  wwc_spi_slave u_spi (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .spi_sck     (spi_sck),
    .spi_cs_n    (spi_cs_n),
    .spi_mosi    (spi_mosi),
    .rd_data     (rd_data),
    .req         (req),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe)
  ); // R27

  // Decoded accesses and timing figures of the present configuration.
  assign cfg_wr  = req.wr && (req.addr == ADDR_CFG_ONE ||
                              req.addr == ADDR_CFG_TWO);
  assign trig_wr = req.wr && req.addr == ADDR_SERVICE;
  assign trig_ok = trig_wr && req.data == SERVICE_PATTERN; // R21 R26
  assign new_cfg1 = (req.addr == ADDR_CFG_ONE) ? req.data : r_reg.cfg1;
  assign new_cfg2 = (req.addr == ADDR_CFG_TWO) ? req.data : r_reg.cfg2;
  assign cfg_ok  = wwc_mode_ok(new_cfg1[MODE_MSB:MODE_LSB]) &&
                   wwc_code4_ok(new_cfg2[PERIOD_MSB:PERIOD_LSB]) &&
                   wwc_code4_ok(new_cfg2[PULSE_MSB:PULSE_LSB]);
  assign period  = wwc_period_ticks(r_reg.cfg2[PERIOD_MSB:PERIOD_LSB],
                   r_reg.cfg1[PRESCALE_MSB:PRESCALE_LSB]); // R12 R18 R19
  assign pulse   = wwc_pulse_ticks(r_reg.cfg2[PULSE_MSB:PULSE_LSB]); // R20
  assign win_act = r_reg.cfg1[MODE_MSB:MODE_LSB] == MODE_WINDOW &&
                   dev_mode == WWC_DEV_NORMAL; // R2
  assign sw_rise = r_reg.sw_out & ~r_reg.prev_sw;
  assign sleep_entry = dev_mode == WWC_DEV_SLEEP && !r_reg.prev_sleep;
  assign in_first_half = r_reg.cnt < (period >> 1);

  // Register read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    rd_data = 8'h00;
    if (req.addr == ADDR_CFG_ONE)
    begin
      rd_data = r_reg.cfg1;
    end
    else if (req.addr == ADDR_CFG_TWO)
    begin
      rd_data = r_reg.cfg2;
    end
    else if (req.addr == ADDR_STATUS)
    begin
      rd_data[ST_OFF_POS]   = r_reg.st == WWC_WD_OFF;
      rd_data[ST_CORRUPTED_ACCESS_FLAG_POS]  = r_reg.corrupted_access_flag;
      rd_data[ST_ILL_POS]   = r_reg.illconf;
      rd_data[ST_TRIGS_POS] = win_act && r_reg.st == WWC_WD_RUN &&
                              in_first_half;
      rd_data[ST_OF_POS]    = r_reg.of_flag;
      rd_data[ST_OFSLP_POS] = r_reg.ofslp;
      rd_data[ST_ETRIG_POS] = r_reg.etrig;
    end
  end

  // Supervisor state machine, status flags and tick divider.
  always_comb
  begin
    r_next             = r_reg;
    r_next.standby_req = 1'b0;
    r_next.wake        = 1'b0;
    r_next.prev_sleep  = dev_mode == WWC_DEV_SLEEP;
    r_next.prev_sw     = r_reg.sw_out;
    if (r_reg.div == DIV_W'(TICK_CYC - 1))
    begin
      r_next.div  = '0;
      r_next.tick = 1'b1;
    end
    else
    begin
      r_next.div  = r_reg.div + DIV_W'(1);
      r_next.tick = 1'b0;
    end
    // Writing one clears a status flag; a set below wins.
    if (req.wr && req.addr == ADDR_STATUS)
    begin
      r_next.corrupted_access_flag    = r_reg.corrupted_access_flag & ~req.data[ST_CORRUPTED_ACCESS_FLAG_POS];
      r_next.illconf = r_reg.illconf & ~req.data[ST_ILL_POS];
      r_next.of_flag = r_reg.of_flag & ~req.data[ST_OF_POS];
      r_next.ofslp   = r_reg.ofslp & ~req.data[ST_OFSLP_POS];
      r_next.etrig   = r_reg.etrig & ~req.data[ST_ETRIG_POS];
    end
    if (cfg_wr && !cfg_ok)
    begin
      r_next.corrupted_access_flag = 1'b1; // R23
    end
    else if (cfg_wr && (dev_mode != WWC_DEV_STANDBY ||
                        r_reg.st == WWC_WD_RST))
    begin
      r_next.illconf = 1'b1; // R9
      if (r_reg.st != WWC_WD_OFF && r_reg.st != WWC_WD_RST)
      begin
        r_next.st  = WWC_WD_RST; // R9
        r_next.cnt = '0;
      end
    end
    else if (cfg_wr)
    begin
      // Accepted write applies at once and restarts the timer.
      r_next.cfg1 = new_cfg1; // R6 R7 R8
      r_next.cfg2 = new_cfg2;
      r_next.cnt  = '0; // R8
      if (new_cfg1[MODE_MSB:MODE_LSB] == MODE_OFF)
      begin
        r_next.st = WWC_WD_OFF;
      end
      else if (r_reg.st == WWC_WD_OFF)
      begin
        // Stale error flags on enabling cause an immediate reset.
        if (r_reg.corrupted_access_flag || r_reg.illconf)
        begin
          r_next.st = WWC_WD_RST;
        end
        else if (new_cfg1[LONG_WIN_POS])
        begin
          r_next.st = WWC_WD_LONG; // R24
        end
        else
        begin
          r_next.st = WWC_WD_RUN;
        end
      end
    end
    else
    begin
      case (r_reg.st)
        WWC_WD_LONG, WWC_WD_RUN:
        begin
          if (sleep_entry)
          begin
            r_next.cnt = '0; // R14 R15
            r_next.st  = r_reg.cfg1[SLEEP_RUN_POS] ? WWC_WD_RUN :
                         WWC_WD_HOLD; // R13
          end
          else if (sw_rise && r_reg.cfg1[LONG_WIN_POS])
          begin
            r_next.cnt = '0; // R16
            r_next.st  = WWC_WD_LONG;
          end
          else if (trig_ok && r_reg.st == WWC_WD_LONG)
          begin
            r_next.cnt = '0;
            r_next.st  = WWC_WD_RUN;
          end
          else if (trig_ok && win_act && in_first_half)
          begin
            r_next.etrig = 1'b1; // R22
            r_next.cnt   = '0;
            r_next.st    = WWC_WD_RST;
          end
          else if (trig_ok)
          begin
            r_next.cnt = '0; // R3 R4
          end
          else if (r_reg.tick)
          begin
            if ((r_reg.st == WWC_WD_LONG &&
                 r_reg.cnt == CNT_W'(LONG_WIN_TICKS - 1)) ||
                (r_reg.st == WWC_WD_RUN && r_reg.cnt >= period - 1'b1))
            begin
              // Overflow: in Sleep this is the periodic wake-up.
              r_next.cnt = '0;
              r_next.st  = WWC_WD_RST; // R22 R24
              if (dev_mode == WWC_DEV_SLEEP)
              begin
                r_next.ofslp = 1'b1; // R5
                r_next.wake  = 1'b1;
              end
              else
              begin
                r_next.of_flag = 1'b1; // R25
              end
            end
            else
            begin
              r_next.cnt = r_reg.cnt + 1'b1;
            end
          end
        end
        WWC_WD_HOLD:
        begin
          if (sw_rise)
          begin
            r_next.cnt = '0; // R15
            r_next.st  = r_reg.cfg1[LONG_WIN_POS] ? WWC_WD_LONG :
                         WWC_WD_RUN;
          end
        end
        WWC_WD_RST:
        begin
          if (r_reg.tick)
          begin
            if (r_reg.cnt >= pulse - 1'b1)
            begin
              r_next.cnt         = '0;
              r_next.standby_req = 1'b1; // R10
              r_next.st          = r_reg.cfg1[LONG_WIN_POS] ? WWC_WD_LONG :
                                   WWC_WD_RUN;
              if (r_reg.cfg1[MODE_MSB:MODE_LSB] == MODE_OFF)
              begin
                r_next.st = WWC_WD_OFF;
              end
            end
            else
            begin
              r_next.cnt = r_reg.cnt + 1'b1;
            end
          end
        end
        default:
        begin
          r_next.cnt = '0;
        end
      endcase
    end
    // Switch stays off through a reset; discharge only if enabled.
    r_next.sw_out    = regulator_switch_req && r_next.st != WWC_WD_RST; // R11
    r_next.discharge = r_next.st == WWC_WD_RST &&
                       r_reg.cfg1[DISCHARGE_POS]; // R17
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      r_reg      <= '0;
      r_reg.st   <= WWC_WD_OFF;
      r_reg.cfg1 <= CFG_ONE_RESET; // R1
      r_reg.cfg2 <= CFG_TWO_RESET;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs from flip-flops; the reset output is decoded from the state register.
  assign regulator_switch_out = r_reg.sw_out;
  assign io_supply_discharge  = r_reg.discharge;
  assign mcu_reset_active     = r_reg.st == WWC_WD_RST;
  assign standby_req          = r_reg.standby_req;
  assign wake_event           = r_reg.wake;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // The off code means the off state except during a reset.
  a_off_mode_state: assert property ( // R1
    r_reg.cfg1[MODE_MSB:MODE_LSB] == MODE_OFF && r_reg.st != WWC_WD_RST
    |-> r_reg.st == WWC_WD_OFF)
    else $error("off code without off state");

  // Window code outside Normal accepts an early trigger.
  a_window_needs_normal: assert property ( // R2
    r_reg.st == WWC_WD_RUN && trig_ok && !win_act && !sleep_entry &&
    !cfg_wr && !(sw_rise && r_reg.cfg1[LONG_WIN_POS])
    |=> r_reg.st == WWC_WD_RUN && r_reg.cnt == '0)
    else $error("trigger outside Normal not accepted");

  // Early trigger in window mode resets and flags it.
  a_early_trigger_reset: assert property ( // R22
    r_reg.st == WWC_WD_RUN && trig_ok && win_act && in_first_half &&
    !sleep_entry && !cfg_wr && !sw_rise
    |=> r_reg.st == WWC_WD_RST && r_reg.etrig ##1 !regulator_switch_out)
    else $error("early trigger did not reset");

  // Illegal configuration outside Standby resets from the long-window or run state.
  a_illegal_cfg_reset: assert property ( // R9
    cfg_wr && cfg_ok && dev_mode != WWC_DEV_STANDBY &&
    (r_reg.st == WWC_WD_RUN || r_reg.st == WWC_WD_LONG)
    |=> r_reg.illconf && mcu_reset_active)
    else $error("illegal configuration not handled");

  // Switch stays off for the first eight cycles of a reset.
  a_reset_holds_switch: assert property ( // R11
    $rose(mcu_reset_active) |=> !regulator_switch_out [*8])
    else $error("switch on during reset");

  // Invalid code leaves configuration untouched.
  a_invalid_code_kept: assert property ( // R23
    cfg_wr && !cfg_ok
    |=> r_reg.corrupted_access_flag && $stable(r_reg.cfg1) && $stable(r_reg.cfg2))
    else $error("invalid code applied");

  // Wrong service value does not restart the count.
  a_bad_service_kept: assert property ( // R26
    trig_wr && !trig_ok && r_reg.st == WWC_WD_RUN && !r_reg.tick &&
    !sleep_entry && !sw_rise
    |=> r_reg.cnt == $past(r_reg.cnt))
    else $error("bad service value moved the timer");

  // Accepted configuration restarts the counter.
  a_cfg_restarts: assert property ( // R8
    cfg_wr && cfg_ok && dev_mode == WWC_DEV_STANDBY &&
    r_reg.st != WWC_WD_RST |=> r_reg.cnt == '0)
    else $error("configuration write did not restart");

  // Counter in the run state never passes the selected period.
  a_period_bound: assert property ( // R18
    r_reg.st == WWC_WD_RUN |-> r_reg.cnt < period)
    else $error("count beyond period");

  // End of reset requests Standby in the same cycle as the exit.
  a_reset_to_standby: assert property ( // R10
    $fell(mcu_reset_active) |-> standby_req)
    else $error("no standby request after reset");

endmodule : wwc_window_supervisor
